// ### src/arith_opcode_decode.sv
`timescale 1ns/100ps
`include "arith_decode_map.svh"
// What this block does
// - Four segment prefixes, two clocks each
// - Sum register form 3/10, immediate reg 000
// - Carry sum forms; immediate 4/16 clocks
// - Difference forms 3/10, immediate reg 101
// - Borrow difference forms, immediate reg 011
// - Invert group reg 011, 3/10 clocks
// - Unpacked sum adjust opcode, 8 clocks
// - Packed sum adjust opcode, 4 clocks
// - Unpacked diff adjust opcode, 7 clocks
// - Packed diff adjust opcode, 4 clocks
// - Unsigned product reg 100, ranged clocks
// - Narrow bus adds 4 per word memory
module arith_opcode_decode
   import arith_decode_pkg::*;
#(
   parameter bit NARROW_BUS = 1'b0
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic byte_ready,
   output logic dec_valid,
   output arith_op_type dec_op,
   output form_type dec_form,
   output logic dec_word,
   output logic dec_mem,
   output logic dec_reg_is_dest,
   output logic [1:0] dec_imm_bytes,
   output logic dec_sign_extend,
   output segment_type dec_segment,
   output logic dec_seg_override,
   output logic [6:0] dec_clk_min,
   output logic [6:0] dec_clk_max,
   output logic dec_unknown
);

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   // Async assert, synchronous release avoids recovery hazards
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // Opcode classification
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      st_opcode = 2'b01,
      st_modrm = 2'b10
   } phase_type;

   phase_type phase;
   logic [7:0] held_op;
   logic prefix_seen;
   segment_type prefix_seg;

   // Classify a leading byte; needs_modrm tells the sequencer to wait
   function automatic arith_op_type classify(input logic [7:0] b, output form_type f,
      output logic needs_modrm);
      arith_op_type o;
      o = op_none_type_v;
      f = form_none;
      needs_modrm = 1'b0;
      if (b == `PFX_CODE_SEG || b == `PFX_STACK_SEG || b == `PFX_DATA_SEG
         || b == `PFX_EXTRA_SEG)
         o = op_seg_prefix;
      else if (b == `OP_UNP_SUM_ADJ)
         o = op_unpacked_bcd_sum_adjust;
      else if (b == `OP_PKD_SUM_ADJ)
         o = op_packed_bcd_sum_adjust;
      else if (b == `OP_UNP_DIFF_ADJ)
         o = op_unpacked_bcd_diff_adjust;
      else if (b == `OP_PKD_DIFF_ADJ)
         o = op_packed_bcd_diff_adjust;
      else if (b[7:2] == `HEAD_SUM_RM)
      begin
         o = op_sum;
         f = form_reg_rm;
         needs_modrm = 1'b1;
      end
      else if (b[7:2] == `HEAD_SUMC_RM)
      begin
         o = op_sum_with_carry;
         f = form_reg_rm;
         needs_modrm = 1'b1;
      end
      else if (b[7:2] == `HEAD_DIFF_RM)
      begin
         o = op_difference;
         f = form_reg_rm;
         needs_modrm = 1'b1;
      end
      else if (b[7:2] == `HEAD_DIFFB_RM)
      begin
         o = op_difference_with_borrow;
         f = form_reg_rm;
         needs_modrm = 1'b1;
      end
      else if (b[7:1] == `HEAD7_SUM_ACC)
      begin
         o = op_sum;
         f = form_imm_acc;
      end
      else if (b[7:1] == `HEAD7_SUMC_ACC)
      begin
         o = op_sum_with_carry;
         f = form_imm_acc;
      end
      else if (b[7:1] == `HEAD7_DIFF_ACC)
      begin
         o = op_difference;
         f = form_imm_acc;
      end
      else if (b[7:1] == `HEAD7_DIFFB_ACC)
      begin
         o = op_difference_with_borrow;
         f = form_imm_acc;
      end
      else if (b[7:2] == `HEAD_IMM_GRP || b[7:1] == `HEAD7_UNARY_GRP)
         needs_modrm = 1'b1;
      return o;
   endfunction : classify

   // Resolve a group opcode by the reg field of its second byte
   function automatic arith_op_type group_op(input logic [7:0] op, input logic [2:0] r);
      arith_op_type o;
      o = op_none_type_v;
      if (op[7:2] == `HEAD_IMM_GRP)
      begin
         unique case (r)
            `REG_SUM: o = op_sum;
            `REG_SUMC: o = op_sum_with_carry;
            `REG_DIFF: o = op_difference;
            `REG_DIFFB: o = op_difference_with_borrow;
            default: o = op_none_type_v;
         endcase
      end
      else if (op[7:1] == `HEAD7_UNARY_GRP)
      begin
         if (r == `REG_INVERT)
            o = op_twos_complement_invert;
         else if (r == `REG_PRODUCT)
            o = op_unsigned_product;
      end
      return o;
   endfunction : group_op

   // ---------------------------------------------------------------
   // Byte sequencer
   // ---------------------------------------------------------------
   arith_op_type lead_op;
   form_type lead_form;
   logic lead_modrm;
   arith_op_type grp_op;
   logic take;

   // The decoder never stalls the queue; one byte per cycle is accepted
   assign byte_ready = 1'b1;
   assign take = byte_valid && byte_ready;

   always_comb
   begin
      lead_op = classify(byte_data, lead_form, lead_modrm);
      grp_op = group_op(held_op, byte_data[5:3]);
   end

   byte_link_if link ();

   // Phase walks opcode then mod-reg-r/m
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase <= st_opcode;
         held_op <= 8'h00;
      end
      else if (take)
      begin
         unique case (phase)
            st_opcode:
            begin
               held_op <= byte_data;
               if (lead_modrm)
                  phase <= st_modrm;
            end
            st_modrm: phase <= st_opcode;
            default: phase <= st_opcode;
         endcase
      end
   end

   // A prefix is remembered until the instruction it qualifies is decoded
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prefix_seen <= 1'b0;
         prefix_seg <= data_segment;
      end
      else if (take && phase == st_opcode && lead_op == op_seg_prefix)
      begin
         prefix_seen <= 1'b1;
         unique case (byte_data)
            `PFX_CODE_SEG: prefix_seg <= code_segment;
            `PFX_STACK_SEG: prefix_seg <= stack_segment;
            `PFX_DATA_SEG: prefix_seg <= data_segment;
            default: prefix_seg <= extra_segment;
         endcase
      end
      else if (link.valid && link.op != op_seg_prefix)
         prefix_seen <= 1'b0;
   end

   // Fields for the timing stage
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link.valid <= 1'b0;
         link.op <= op_none_type_v;
         link.form <= form_none;
         link.is_word <= 1'b0;
         link.is_mem <= 1'b0;
         link.dest_is_reg <= 1'b0;
         link.imm_bytes <= 2'h0;
         link.sign_extend <= 1'b0;
         link.segment <= data_segment;
         dec_unknown <= 1'b0;
      end
      else
      begin
         link.valid <= 1'b0;
         dec_unknown <= 1'b0;
         if (take && phase == st_opcode && !lead_modrm)
         begin
            link.valid <= (lead_op != op_none_type_v);
            dec_unknown <= (lead_op == op_none_type_v);
            link.op <= lead_op;
            link.form <= lead_form;
            link.is_word <= (lead_form == form_imm_acc) && byte_data[0];
            link.is_mem <= 1'b0;
            link.dest_is_reg <= 1'b0;
            link.imm_bytes <= (lead_form == form_imm_acc) ? {byte_data[0], !byte_data[0]}
               : 2'h0;
            link.sign_extend <= 1'b0;
         end
         else if (take && phase == st_modrm)
         begin
            link.is_word <= held_op[0];
            link.is_mem <= (byte_data[7:6] != 2'b11);
            link.dest_is_reg <= (held_op[7:2] != `HEAD_IMM_GRP) && held_op[1];
            if (held_op[7:2] == `HEAD_IMM_GRP || held_op[7:1] == `HEAD7_UNARY_GRP)
            begin
               link.valid <= (grp_op != op_none_type_v);
               dec_unknown <= (grp_op == op_none_type_v);
               link.op <= grp_op;
               link.form <= (held_op[7:2] == `HEAD_IMM_GRP) ? form_imm_rm : form_reg_rm;
               // No data bytes for the unary group; two only when w=1 and s does not sign-extend a single byte, one byte otherwise
               link.imm_bytes <= (held_op[7:2] != `HEAD_IMM_GRP) ? 2'h0
                  : (held_op[1:0] == 2'b01) ? 2'h2 : 2'h1;
               link.sign_extend <= (held_op[7:2] == `HEAD_IMM_GRP) && (held_op[1:0] == 2'b11);
            end
            else
            begin
               link.valid <= 1'b1;
               link.op <= classify_op(held_op);
               link.form <= form_reg_rm;
               link.imm_bytes <= 2'h0;
               link.sign_extend <= 1'b0;
            end
         end
         link.segment <= prefix_seg;
      end
   end

   // Plain op lookup for a held reg-rm opcode
   function automatic arith_op_type classify_op(input logic [7:0] b);
      form_type f;
      logic m;
      return classify(b, f, m);
   endfunction : classify_op

   // ---------------------------------------------------------------
   // Timing stage and outputs
   // ---------------------------------------------------------------
   clock_cost #(
      .NARROW_BUS(NARROW_BUS)
   ) u_cost (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .link(link),
      .cost_valid(dec_valid),
      .cost_min(dec_clk_min),
      .cost_max(dec_clk_max)
   );

   // Decode fields are held alongside the cost so both appear together
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dec_op <= op_none_type_v;
         dec_form <= form_none;
         dec_word <= 1'b0;
         dec_mem <= 1'b0;
         dec_reg_is_dest <= 1'b0;
         dec_imm_bytes <= 2'h0;
         dec_sign_extend <= 1'b0;
         dec_segment <= data_segment;
         dec_seg_override <= 1'b0;
      end
      else if (link.valid)
      begin
         dec_op <= link.op;
         dec_form <= link.form;
         dec_word <= link.is_word;
         dec_mem <= link.is_mem;
         dec_reg_is_dest <= link.dest_is_reg;
         dec_imm_bytes <= link.imm_bytes;
         dec_sign_extend <= link.sign_extend;
         // A prefix reports the segment it has just selected
         dec_segment <= (link.op == op_seg_prefix) ? prefix_seg : link.segment;
         dec_seg_override <= (link.op == op_seg_prefix) || prefix_seen;
      end
   end

endmodule : arith_opcode_decode

// ### src/arith_decode_map.svh
`ifndef ARITH_DECODE_MAP_SVH
`define ARITH_DECODE_MAP_SVH

// Segment-override prefixes
`define PFX_CODE_SEG 8'h2E
`define PFX_STACK_SEG 8'h36
`define PFX_DATA_SEG 8'h3E
`define PFX_EXTRA_SEG 8'h26

// Single-byte BCD adjusts
`define OP_UNP_SUM_ADJ 8'h37
`define OP_PKD_SUM_ADJ 8'h27
`define OP_UNP_DIFF_ADJ 8'h3F
`define OP_PKD_DIFF_ADJ 8'h2F

// Six-bit opcode heads (top six bits)
`define HEAD_SUM_RM 6'h00
`define HEAD_SUMC_RM 6'h04
`define HEAD_DIFF_RM 6'h0A
`define HEAD_DIFFB_RM 6'h06
`define HEAD_IMM_GRP 6'h20
// Seven-bit opcode heads (top seven bits)
`define HEAD7_SUM_ACC 7'h02
`define HEAD7_SUMC_ACC 7'h0A
`define HEAD7_DIFF_ACC 7'h16
`define HEAD7_DIFFB_ACC 7'h0E
`define HEAD7_UNARY_GRP 7'h7B

// Reg-field selectors in the group opcodes
`define REG_SUM 3'h0
`define REG_SUMC 3'h2
`define REG_DIFFB 3'h3
`define REG_DIFF 3'h5
`define REG_INVERT 3'h3
`define REG_PRODUCT 3'h4

// Clock counts
`define CLK_PREFIX 7'h02
`define CLK_RM_REG 7'h03
`define CLK_RM_MEM 7'h0A
`define CLK_IMM_REG 7'h04
`define CLK_IMM_MEM 7'h10
`define CLK_ACC_BYTE 7'h03
`define CLK_ACC_WORD 7'h04
`define CLK_UNP_SUM_ADJ 7'h08
`define CLK_PKD_ADJ 7'h04
`define CLK_UNP_DIFF_ADJ 7'h07
`define CLK_MUL_RB_MIN 7'h1A
`define CLK_MUL_RB_MAX 7'h1C
`define CLK_MUL_RW_MIN 7'h23
`define CLK_MUL_RW_MAX 7'h25
`define CLK_MUL_MB_MIN 7'h20
`define CLK_MUL_MB_MAX 7'h22
`define CLK_MUL_MW_MIN 7'h29
`define CLK_MUL_MW_MAX 7'h2B
`define CLK_NARROW_WORD_MEM 7'h04

`endif

// ### src/arith_decode_pkg.sv
package arith_decode_pkg;

   typedef enum logic [3:0] {
      op_none_type_v = 4'h0,
      op_seg_prefix = 4'h1,
      op_sum = 4'h2,
      op_sum_with_carry = 4'h3,
      op_difference = 4'h4,
      op_difference_with_borrow = 4'h5,
      op_twos_complement_invert = 4'h6,
      op_unpacked_bcd_sum_adjust = 4'h7,
      op_packed_bcd_sum_adjust = 4'h8,
      op_unpacked_bcd_diff_adjust = 4'h9,
      op_packed_bcd_diff_adjust = 4'hA,
      op_unsigned_product = 4'hB
   } arith_op_type;

   typedef enum logic [1:0] {
      code_segment = 2'h0,
      stack_segment = 2'h1,
      data_segment = 2'h2,
      extra_segment = 2'h3
   } segment_type;

   typedef enum logic [1:0] {
      form_none = 2'h0,
      form_reg_rm = 2'h1,
      form_imm_rm = 2'h2,
      form_imm_acc = 2'h3
   } form_type;

endpackage : arith_decode_pkg

// ### src/byte_link_if.sv
`timescale 1ns/100ps
// Carries one captured decode result from the byte sequencer to its timing stage
interface byte_link_if;
   import arith_decode_pkg::*;
   logic valid;
   arith_op_type op;
   form_type form;
   logic is_word;
   logic is_mem;
   logic dest_is_reg;
   logic [1:0] imm_bytes;
   logic sign_extend;
   segment_type segment;

   modport source (output valid, op, form, is_word, is_mem, dest_is_reg, imm_bytes,
      sign_extend, segment);
   modport sink (input valid, op, form, is_word, is_mem, dest_is_reg, imm_bytes,
      sign_extend, segment);
endinterface : byte_link_if

// ### src/clock_cost.sv
`timescale 1ns/100ps
`include "arith_decode_map.svh"
// Turns a decoded operation into its execution clock range
module clock_cost
   import arith_decode_pkg::*;
#(
   parameter bit NARROW_BUS = 1'b0
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   byte_link_if.sink link,
   output logic cost_valid,
   output logic [6:0] cost_min,
   output logic [6:0] cost_max
);

   logic [6:0] next_min;
   logic [6:0] next_max;
   logic [6:0] extra;

   // Narrow bus pays for each extra byte of a word memory transfer
   assign extra = (NARROW_BUS && link.is_word && link.is_mem) ? `CLK_NARROW_WORD_MEM : 7'h00;

   // Table lookup of clock counts
   always_comb
   begin
      next_min = 7'h00;
      next_max = 7'h00;
      unique case (link.op)
         op_seg_prefix:
         begin
            next_min = `CLK_PREFIX;
            next_max = `CLK_PREFIX;
         end
         op_sum, op_sum_with_carry, op_difference, op_difference_with_borrow:
         begin
            if (link.form == form_imm_acc)
               next_min = link.is_word ? `CLK_ACC_WORD : `CLK_ACC_BYTE;
            else if (link.form == form_imm_rm)
               next_min = link.is_mem ? `CLK_IMM_MEM : `CLK_IMM_REG;
            else
               next_min = link.is_mem ? `CLK_RM_MEM : `CLK_RM_REG;
            next_max = next_min;
         end
         op_twos_complement_invert:
         begin
            next_min = link.is_mem ? `CLK_RM_MEM : `CLK_RM_REG;
            next_max = next_min;
         end
         op_unpacked_bcd_sum_adjust:
         begin
            next_min = `CLK_UNP_SUM_ADJ;
            next_max = next_min;
         end
         op_packed_bcd_sum_adjust, op_packed_bcd_diff_adjust:
         begin
            next_min = `CLK_PKD_ADJ;
            next_max = next_min;
         end
         op_unpacked_bcd_diff_adjust:
         begin
            next_min = `CLK_UNP_DIFF_ADJ;
            next_max = next_min;
         end
         op_unsigned_product:
         begin
            if (link.is_mem)
            begin
               next_min = link.is_word ? `CLK_MUL_MW_MIN : `CLK_MUL_MB_MIN;
               next_max = link.is_word ? `CLK_MUL_MW_MAX : `CLK_MUL_MB_MAX;
            end
            else
            begin
               next_min = link.is_word ? `CLK_MUL_RW_MIN : `CLK_MUL_RB_MIN;
               next_max = link.is_word ? `CLK_MUL_RW_MAX : `CLK_MUL_RB_MAX;
            end
         end
         default:
         begin
            next_min = 7'h00;
            next_max = 7'h00;
         end
      endcase
   end

   // Registered cost, one cycle behind the decode
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cost_valid <= 1'b0;
         cost_min <= 7'h00;
         cost_max <= 7'h00;
      end
      else
      begin
         cost_valid <= link.valid;
         cost_min <= next_min + extra;
         cost_max <= next_max + extra;
      end
   end

endmodule : clock_cost

// ### verification/arith_opcode_decode_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------
// Decode output checker
// ----------------------------------------
module arith_opcode_decode_monitor
   import arith_decode_pkg::*;
#(
   parameter bit NARROW_BUS = 1'b0
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_ready,
   input wire logic dec_valid,
   input arith_op_type dec_op,
   input form_type dec_form,
   input wire logic dec_word,
   input wire logic dec_mem,
   input wire logic [1:0] dec_imm_bytes,
   input wire logic dec_sign_extend,
   input wire logic dec_seg_override,
   input wire logic [6:0] dec_clk_min,
   input wire logic [6:0] dec_clk_max,
   input wire logic dec_unknown
);
   logic [6:0] nx;
   logic v;
   // Narrow bus pays four more clocks per word memory transfer
   assign nx = (NARROW_BUS && dec_word && dec_mem) ? 7'h04 : 7'h00;
   assign v = dec_valid;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   prefix_cost_a: assert property (v && dec_op == op_seg_prefix |-> dec_clk_min == 7'h02
      && dec_clk_max == 7'h02 && dec_seg_override) else $error("prefix cost wrong");
   answer_delay_a: assert property (v |-> $past(byte_valid && byte_ready, 2))
      else $error("no byte taken two edges before");
   rm_cost_a: assert property (v && dec_form == form_reg_rm && dec_op != op_twos_complement_invert
      && dec_op != op_unsigned_product |-> dec_clk_min == dec_clk_max
      && dec_clk_min == (dec_mem ? 7'h0A : 7'h03) + nx) else $error("reg form cost wrong");
   imm_cost_a: assert property (v && dec_form == form_imm_rm |-> dec_clk_max == dec_clk_min
      && dec_clk_min == (dec_mem ? 7'h10 : 7'h04) + nx) else $error("immediate cost wrong");
   acc_cost_a: assert property (v && dec_form == form_imm_acc |-> !dec_mem
      && dec_clk_min == (dec_word ? 7'h04 : 7'h03) && dec_imm_bytes == {dec_word, !dec_word})
      else $error("accumulator form wrong");
   imm_width_a: assert property (v && dec_form == form_imm_rm |-> (dec_sign_extend -> dec_word)
      && dec_imm_bytes == ((dec_word && !dec_sign_extend) ? 2'h2 : 2'h1))
      else $error("immediate byte count wrong");
   invert_cost_a: assert property (v && dec_op == op_twos_complement_invert |->
      dec_clk_min == dec_clk_max && dec_clk_min == (dec_mem ? 7'h0A : 7'h03) + nx)
      else $error("invert cost wrong");
   unp_sum_adj_a: assert property (v && dec_op == op_unpacked_bcd_sum_adjust |->
      dec_clk_min == 7'h08 && dec_clk_max == 7'h08 && !dec_mem) else $error("adjust cost wrong");
   pkd_sum_adj_a: assert property (v && dec_op == op_packed_bcd_sum_adjust |->
      dec_clk_min == 7'h04 && dec_clk_max == 7'h04) else $error("adjust cost wrong");
   unp_diff_adj_a: assert property (v && dec_op == op_unpacked_bcd_diff_adjust |->
      dec_clk_min == 7'h07 && dec_clk_max == 7'h07) else $error("adjust cost wrong");
   pkd_diff_adj_a: assert property (v && dec_op == op_packed_bcd_diff_adjust |->
      dec_clk_min == 7'h04 && dec_clk_max == 7'h04) else $error("adjust cost wrong");
   product_range_a: assert property (v && dec_op == op_unsigned_product |->
      dec_clk_max == dec_clk_min + 7'h02 && dec_clk_min == (dec_mem ? (dec_word ? 7'h29 : 7'h20)
      : (dec_word ? 7'h23 : 7'h1A)) + nx) else $error("product cost wrong");

   prefix_c: cover property (v && dec_op == op_seg_prefix);
   product_c: cover property (v && dec_op == op_unsigned_product && dec_mem && dec_word);
   unknown_c: cover property (dec_unknown);
endmodule : arith_opcode_decode_monitor

bind arith_opcode_decode arith_opcode_decode_monitor #(.NARROW_BUS(NARROW_BUS)) monitor_i (.*);

// ### verification/prefetch_feed.sv
`timescale 1ns/100ps
// ----------------------------------------
// Prefetch queue model
// ----------------------------------------
module prefetch_feed
(
   input wire logic core_clk,
   input wire logic byte_ready,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   initial
   begin
      byte_valid = 1'b0;
      byte_data = 8'hA5;
   end
   // Idle data toggles so a stale byte never looks fresh
   always @(negedge core_clk)
      if (byte_valid === 1'b0)
         byte_data = ~byte_data;

   // Holds the byte until it is taken at a rising edge
   task automatic offer(input logic [7:0] b);
      byte_valid = 1'b1;
      byte_data = b;
      @(posedge core_clk);
      while (byte_ready !== 1'b1)
         @(posedge core_clk);
      #1;
   endtask : offer

   task automatic idle();
      byte_valid = 1'b0;
   endtask : idle
endmodule : prefetch_feed

// ### verification/arith_opcode_decode_tb.sv
`timescale 1ns/100ps
module arith_opcode_decode_tb;
   import arith_decode_pkg::*;
   // ----------------------------------------
   // Signals and bookkeeping
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic byte_valid, byte_ready, dec_valid, dec_word, dec_mem, dec_reg_is_dest;
   logic dec_sign_extend, dec_seg_override, dec_unknown;
   logic [7:0] byte_data;
   arith_op_type dec_op;
   form_type dec_form;
   logic [1:0] dec_imm_bytes;
   segment_type dec_segment;
   logic [6:0] dec_clk_min, dec_clk_max;
   logic [28:0] got[$];
   segment_type cur_seg = data_segment;
   logic cur_ovr = 1'b0;
   int unk_cnt = 0;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;

   always #5 core_clk = ~core_clk;

   // Narrow variant exercises the word memory surcharge
   arith_opcode_decode #(.NARROW_BUS(1'b1)) DUT (.*);

   prefetch_feed feed (.*);

   // Collect results mid-cycle, once settled
   always @(negedge core_clk)
   begin
      if (dec_valid === 1'b1)
         got.push_back({dec_op, dec_form, dec_word, dec_mem, dec_reg_is_dest, dec_imm_bytes,
            dec_sign_extend, dec_segment, dec_seg_override, dec_clk_min, dec_clk_max});
      if (dec_unknown === 1'b1)
         unk_cnt++;
   end

   // Cuts a hang short; the full run needs about a hundred cycles
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         conclude();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [28:0] seen, input logic [28:0] want);
      comparisons++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, want, seen);
      end
   endtask : chk

   // Flags f are {word, mem, reg_is_dest, imm_bytes[1:0], sign_extend}; loose ignores form and d
   task automatic expect_op(input arith_op_type op, input form_type fm, input logic [5:0] f,
      input logic [6:0] mn, input logic [6:0] mx, input bit loose);
      logic [28:0] want;
      logic [28:0] mask;
      int n;
      want = {op, fm, f, cur_seg, cur_ovr, mn, mx};
      mask = loose ? ~29'h01900000 : '1;
      n = 0;
      while (got.size() == 0 && n < 8)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (got.size() == 0)
         chk("decode presence", 29'h0, 29'h1);
      else
         chk("decode record", got.pop_front() & mask, want & mask);
   endtask : expect_op

   task automatic send(input logic [7:0] a, input logic [7:0] b);
      feed.offer(a);
      feed.offer(b);
   endtask : send

   task automatic conclude();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_sum();
      send(8'h00, 8'hC0);
      send(8'h03, 8'h06);
      send(8'h80, 8'hC0);
      send(8'h81, 8'h06);
      send(8'h83, 8'hC0);
      send(8'h04, 8'h05);
      feed.idle();
      expect_op(op_sum, form_reg_rm, 6'h00, 7'h03, 7'h03, 0);
      expect_op(op_sum, form_reg_rm, 6'h38, 7'h0E, 7'h0E, 0);
      expect_op(op_sum, form_imm_rm, 6'h02, 7'h04, 7'h04, 0);
      expect_op(op_sum, form_imm_rm, 6'h34, 7'h14, 7'h14, 0);
      expect_op(op_sum, form_imm_rm, 6'h23, 7'h04, 7'h04, 0);
      expect_op(op_sum, form_imm_acc, 6'h02, 7'h03, 7'h03, 0);
      expect_op(op_sum, form_imm_acc, 6'h24, 7'h04, 7'h04, 0);
   endtask : t_sum

   task automatic t_carry_borrow();
      send(8'h12, 8'hD8);
      send(8'h15, 8'h80);
      send(8'hD0, 8'h18);
      send(8'hC0, 8'h1D);
      send(8'h83, 8'h5E);
      feed.idle();
      expect_op(op_sum_with_carry, form_reg_rm, 6'h08, 7'h03, 7'h03, 0);
      expect_op(op_sum_with_carry, form_imm_acc, 6'h24, 7'h04, 7'h04, 0);
      expect_op(op_sum_with_carry, form_imm_rm, 6'h02, 7'h04, 7'h04, 0);
      expect_op(op_difference_with_borrow, form_reg_rm, 6'h00, 7'h03, 7'h03, 0);
      expect_op(op_difference_with_borrow, form_imm_acc, 6'h24, 7'h04, 7'h04, 0);
      expect_op(op_difference_with_borrow, form_imm_rm, 6'h33, 7'h14, 7'h14, 0);
   endtask : t_carry_borrow

   task automatic t_difference();
      send(8'h2B, 8'h06);
      send(8'h2C, 8'h81);
      feed.offer(8'hE8);
      feed.idle();
      expect_op(op_difference, form_reg_rm, 6'h38, 7'h0E, 7'h0E, 0);
      expect_op(op_difference, form_imm_acc, 6'h02, 7'h03, 7'h03, 0);
      expect_op(op_difference, form_imm_rm, 6'h24, 7'h04, 7'h04, 0);
   endtask : t_difference

   task automatic t_unary();
      send(8'hF6, 8'hD8);
      send(8'hF7, 8'h1E);
      send(8'hF6, 8'hE0);
      send(8'hF7, 8'hE0);
      send(8'hF6, 8'h26);
      send(8'hF7, 8'h26);
      feed.idle();
      expect_op(op_twos_complement_invert, form_reg_rm, 6'h00, 7'h03, 7'h03, 1);
      expect_op(op_twos_complement_invert, form_reg_rm, 6'h30, 7'h0E, 7'h0E, 1);
      expect_op(op_unsigned_product, form_reg_rm, 6'h00, 7'h1A, 7'h1C, 1);
      expect_op(op_unsigned_product, form_reg_rm, 6'h20, 7'h23, 7'h25, 1);
      expect_op(op_unsigned_product, form_reg_rm, 6'h10, 7'h20, 7'h22, 1);
      expect_op(op_unsigned_product, form_reg_rm, 6'h30, 7'h2D, 7'h2F, 1);
   endtask : t_unary

   task automatic t_adjust();
      send(8'h37, 8'h27);
      send(8'h3F, 8'h2F);
      feed.idle();
      expect_op(op_unpacked_bcd_sum_adjust, form_none, 6'h00, 7'h08, 7'h08, 0);
      expect_op(op_packed_bcd_sum_adjust, form_none, 6'h00, 7'h04, 7'h04, 0);
      expect_op(op_unpacked_bcd_diff_adjust, form_none, 6'h00, 7'h07, 7'h07, 0);
      expect_op(op_packed_bcd_diff_adjust, form_none, 6'h00, 7'h04, 7'h04, 0);
   endtask : t_adjust

   // Bytes outside the table pulse unknown only
   task automatic t_unknown();
      feed.offer(8'h90);
      send(8'hF6, 8'hC0);
      send(8'h80, 8'hC8);
      feed.idle();
      repeat (4) @(posedge core_clk);
      #1;
      chk("unknown pulses", 29'(unk_cnt), 29'h3);
      chk("stray decodes", 29'(got.size()), 29'h0);
   endtask : t_unknown

   task automatic t_prefix();
      logic [7:0] pfx [4] = '{8'h2E, 8'h36, 8'h3E, 8'h26};
      segment_type sg [4] = '{code_segment, stack_segment, data_segment, extra_segment};
      for (int i = 0; i < 4; i++)
      begin
         feed.offer(pfx[i]);
         send(8'h00, 8'hC0);
         feed.idle();
         cur_seg = sg[i];
         cur_ovr = 1'b1;
         expect_op(op_seg_prefix, form_none, 6'h00, 7'h02, 7'h02, 0);
         expect_op(op_sum, form_reg_rm, 6'h00, 7'h03, 7'h03, 0);
      end
   endtask : t_prefix

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (10) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      t_sum();
      t_carry_borrow();
      t_difference();
      t_unary();
      t_adjust();
      t_unknown();
      t_prefix();
      conclude();
   end
endmodule : arith_opcode_decode_tb
